/* hw/seek_position_control.v */
// seek sequencing: track countdown, velocity/position handover, settle,
// return-to-zero seek and master clear on unsafe fault.
// assumes all inputs except presetn are synchronous to pclk; track_crossing_pulse and
// control select are one-cycle pulses from upstream logic.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "seek_position_control_defines.vh"

module seek_position_control #(
	parameter integer SETTLE_CYCLES = `SETTLE_NS / `CLK_NS,
	parameter integer DIFF_W = 8
) (
	input wire pclk, // bus and logic clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output wire pready, // apb ready
	output wire pslverr, // apb error on unmapped address
	input wire control_select, // tag strobe from control unit
	input wire address_bus_bit0, // address bus bit 0
	input wire address_bus_bit6, // address bus bit 6
	input wire track_crossing_pulse, // one pulse per track passed
	input wire speed_in_window, // arm speed within window
	input wire mech_on_cylinder_window, // mechanical on-cylinder window
	input wire optical_zero, // optical zero sensor
	input wire even_track_zone, // area around even track
	input wire park_switch_active, // retract micro-switch
	input wire unsafe_two, // second unsafe condition
	input wire start_clear, // external master clear request
	input wire [15:0] position_error, // position-derived error sample
	input wire [15:0] speed_difference, // speed-difference sample
	output reg [15:0] driver_signal, // selected servo drive value
	output wire position_servo_mode, // positioning mode
	output wire slow, // slow signal
	output wire max_at_converter, // max at converter
	output wire diff_count_at_one, // counter equals one
	output wire zero_seek_command_n, // return-to-zero command, active low
	output wire zero_seek_active, // return-to-zero seek
	output wire forward_direction, // carriage moves forward
	output wire track_zero, // at track zero
	output wire on_cylinder_prep, // on-cylinder preparation
	output wire on_cylinder_out, // on-cylinder to control unit
	output wire timing_counter_clear, // timing counter held reset
	output wire edge_polarity_select, // pass position uninverted when high
	output wire odd_track_select, // odd target track in positioning
	output wire parked_position, // arm parked
	output wire amp_block, // power amplifier input blocked
	output wire fault_lamp, // fault indicator
	output wire master_clear, // master clear pulse
	output wire unsafe_two_out, // unsafe two to control unit
	output wire alert_out // attention to control unit
);

	// ****************************************
	// state
	// ****************************************
	reg [DIFF_W-1:0] diff_ff;
	reg [7:0] cyl_addr_ff;
	reg count_enable_ff;
	reg end_of_position_ff;
	reg slow_motion_ff;
	reg normal_seek_ff;
	reg forward_direction_ff;
	reg carriage_in_pack_ff;
	reg park_switch_ff;
	reg unit_unsafe_ff;
	reg on_cyl_ff;
	reg zero_cmd_ff;
	reg oz_seen_ff;
	reg unsafe_d_ff;
	reg [31:0] settle_cnt_ff;
	reg [31:0] settle_len_ff;
	reg [31:0] nxt_rdata;

	wire wr_en;
	wire rd_en;
	wire addr_ok;
	wire seek_start;
	wire slow_reverse;
	wire forward_direction_set_term;
	wire slow_seek_pos_clear_term;
	wire position_clear_pulse;
	wire settle_oneshot_trig;
	wire settle_delay_oneshot;
	wire unsafe_rise;

	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `ADDR_CTRL) || (a == `ADDR_CYL) || (a == `ADDR_DIFF) ||
				(a == `ADDR_STATUS) || (a == `ADDR_SETTLE);
		end
	endfunction

	// ****************************************
	// apb slave
	// ****************************************
	assign pready = 1'b1;
	assign addr_ok = is_mapped(paddr);
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en = psel & penable & pwrite & addr_ok;
	assign rd_en = psel & ~penable & ~pwrite;
	assign seek_start = wr_en && (paddr == `ADDR_CTRL) && pwdata[`CTRL_SEEK_BIT];

	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (paddr)
			`ADDR_CYL: nxt_rdata[7:0] = cyl_addr_ff;
			`ADDR_DIFF: nxt_rdata[DIFF_W-1:0] = diff_ff;
			`ADDR_SETTLE: nxt_rdata = settle_len_ff;
			`ADDR_STATUS: begin
				nxt_rdata[`ST_COUNT_EN] = count_enable_ff;
				nxt_rdata[`ST_END_POS] = end_of_position_ff;
				nxt_rdata[`ST_SLOW_MOT] = slow_motion_ff;
				nxt_rdata[`ST_NORM_SEEK] = normal_seek_ff;
				nxt_rdata[`ST_FWD] = forward_direction_ff;
				nxt_rdata[`ST_ON_CYL] = on_cyl_ff;
				nxt_rdata[`ST_UNSAFE] = unit_unsafe_ff;
				nxt_rdata[`ST_PARKED] = park_switch_ff;
				nxt_rdata[`ST_ZERO_SEEK] = zero_seek_active;
				nxt_rdata[`ST_MAX_DAC] = max_at_converter;
				nxt_rdata[`ST_CARRIAGE] = carriage_in_pack_ff;
			end
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data is captured in the setup cycle so it stands through the access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= nxt_rdata;
		end
	end

	// ****************************************
	// fault and master clear
	// ****************************************
	// only the rising edge clears; a held level would keep the unit in clear
	assign unsafe_rise = unsafe_two & ~unsafe_d_ff;
	assign master_clear = unsafe_rise | start_clear;
	assign fault_lamp = unit_unsafe_ff;
	assign unsafe_two_out = unit_unsafe_ff;
	assign alert_out = unit_unsafe_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unsafe_d_ff <= 1'b0;
			unit_unsafe_ff <= 1'b0;
			carriage_in_pack_ff <= 1'b0;
			park_switch_ff <= 1'b0;
		end else begin
			unsafe_d_ff <= unsafe_two;
			if (unsafe_rise) begin
				unit_unsafe_ff <= 1'b1;
			end else if (start_clear) begin
				unit_unsafe_ff <= 1'b0;
			end
			if (master_clear) begin
				carriage_in_pack_ff <= 1'b0;
			end else if (seek_start) begin
				carriage_in_pack_ff <= 1'b1;
			end
			if (park_switch_active) begin
				park_switch_ff <= 1'b1;
			end else if (seek_start) begin
				park_switch_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// track counting
	// ****************************************
	// forced high once count enable falls
	assign max_at_converter = count_enable_ff ? (diff_ff < `MAX_DAC_LIMIT) : 1'b1;
	assign diff_count_at_one = (diff_ff == `DIFF_ONE);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diff_ff <= {DIFF_W{1'b0}};
			count_enable_ff <= 1'b0;
			cyl_addr_ff <= 8'h00;
		end else if (master_clear) begin
			count_enable_ff <= 1'b0;
			cyl_addr_ff <= 8'h00;
		end else if (seek_start) begin
			diff_ff <= pwdata[8+DIFF_W-1:8];
			cyl_addr_ff <= pwdata[31:24];
			count_enable_ff <= 1'b1;
		end else if (track_crossing_pulse && count_enable_ff) begin
			diff_ff <= diff_ff - {{(DIFF_W-1){1'b0}}, 1'b1};
			// clear on pulse at diff one
			if (diff_count_at_one) begin
				count_enable_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// end of position, slow motion, direction
	// ****************************************
	// zero seek request
	assign zero_seek_command_n = ~zero_cmd_ff;
	assign zero_seek_active = normal_seek_ff & slow_motion_ff;
	assign track_zero = oz_seen_ff & even_track_zone;
	assign slow_reverse = ~track_zero;
	assign forward_direction_set_term = track_zero & zero_seek_active;
	assign slow_seek_pos_clear_term = normal_seek_ff & track_zero;
	assign position_clear_pulse = (slow_seek_pos_clear_term & slow_motion_ff) | master_clear;
	assign slow = end_of_position_ff & ~position_clear_pulse;
	assign position_servo_mode = end_of_position_ff | park_switch_ff;
	assign parked_position = park_switch_ff;
	assign amp_block = park_switch_ff;
	assign forward_direction = forward_direction_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_of_position_ff <= 1'b0;
			slow_motion_ff <= 1'b1;
			normal_seek_ff <= 1'b0;
			forward_direction_ff <= 1'b0;
			zero_cmd_ff <= 1'b0;
			oz_seen_ff <= 1'b0;
		end else begin
			zero_cmd_ff <= control_select & address_bus_bit6;
			if (optical_zero) begin
				oz_seen_ff <= 1'b1;
			end else if (!even_track_zone) begin
				oz_seen_ff <= 1'b0;
			end
			// end of position reset by clear
			if (position_clear_pulse || seek_start) begin
				end_of_position_ff <= 1'b0;
			// set at target or in window
			end else if ((count_enable_ff && track_crossing_pulse && diff_count_at_one)
				|| speed_in_window) begin
				end_of_position_ff <= 1'b1;
			end
			if (master_clear || zero_cmd_ff) begin
				slow_motion_ff <= 1'b1;
			end else if (settle_delay_oneshot && settle_cnt_ff == 32'h0000_0001) begin
				slow_motion_ff <= 1'b0;
			end
			if (master_clear) begin
				normal_seek_ff <= 1'b0;
			end else if (carriage_in_pack_ff) begin
				normal_seek_ff <= 1'b1;
			end
			if (master_clear) begin
				forward_direction_ff <= 1'b0;
			end else if (forward_direction_set_term) begin
				forward_direction_ff <= 1'b1;
			end else if (zero_seek_active && slow_reverse) begin
				forward_direction_ff <= 1'b0;
			end else if (seek_start) begin
				forward_direction_ff <= pwdata[`CTRL_DIR_BIT];
			end
		end
	end

	// ****************************************
	// settling one-shot and on-cylinder
	// ****************************************
	// retriggered settle
	assign settle_oneshot_trig = mech_on_cylinder_window & end_of_position_ff & ~on_cyl_ff;
	assign settle_delay_oneshot = (settle_cnt_ff != 32'h0000_0000);
	assign on_cylinder_prep = on_cyl_ff;
	assign on_cylinder_out = on_cyl_ff;
	assign timing_counter_clear = ~on_cyl_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_cnt_ff <= 32'h0000_0000;
			settle_len_ff <= 32'h0000_0000;
			on_cyl_ff <= 1'b0;
		end else begin
			if (wr_en && paddr == `ADDR_SETTLE) begin
				settle_len_ff <= pwdata;
			end
			if (!end_of_position_ff || master_clear) begin
				settle_cnt_ff <= 32'h0000_0000;
				on_cyl_ff <= 1'b0;
			end else if (settle_oneshot_trig && !settle_delay_oneshot) begin
				settle_cnt_ff <= (settle_len_ff != 32'h0000_0000) ? settle_len_ff :
					SETTLE_CYCLES;
			end else if (settle_delay_oneshot) begin
				if (settle_cnt_ff == 32'h0000_0001) begin
					on_cyl_ff <= 1'b1;
				end
				settle_cnt_ff <= mech_on_cylinder_window ? settle_cnt_ff - 32'h0000_0001 :
					((settle_len_ff != 32'h0000_0000) ? settle_len_ff : SETTLE_CYCLES);
			end
		end
	end

	// ****************************************
	// servo routing
	// ****************************************
	// polarity is inverted cylinder address register bit zero
	assign edge_polarity_select = ~cyl_addr_ff[0];
	assign odd_track_select = position_servo_mode & address_bus_bit0;

	// parked arm gets a zero drive on top of the blocked amplifier
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			driver_signal <= 16'h0000;
		end else if (park_switch_ff) begin
			driver_signal <= 16'h0000;
		end else if (position_servo_mode) begin
			driver_signal <= edge_polarity_select ? position_error : -position_error;
		end else begin
			driver_signal <= speed_difference;
		end
	end

	// a non-zero settle register overrides SETTLE_CYCLES, so software
	// can shorten the wait without rebuilding the block

endmodule // seek_position_control
`default_nettype wire

/* hw/seek_position_control_defines.vh */
// constants for the seek sequencing block
// assumes inclusion by bare name from the design file
`ifndef SEEK_POSITION_CONTROL_DEFINES_VH
`define SEEK_POSITION_CONTROL_DEFINES_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_CTRL 12'h000
`define ADDR_CYL 12'h004
`define ADDR_DIFF 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_SETTLE 12'h010

// ****************************************
// ctrl fields (write pulses)
// ****************************************
`define CTRL_SEEK_BIT 0
`define CTRL_DIR_BIT 1

// ****************************************
// status fields
// ****************************************
`define ST_COUNT_EN 0
`define ST_END_POS 1
`define ST_SLOW_MOT 2
`define ST_NORM_SEEK 3
`define ST_FWD 4
`define ST_ON_CYL 5
`define ST_UNSAFE 6
`define ST_PARKED 7
`define ST_ZERO_SEEK 8
`define ST_MAX_DAC 9
`define ST_CARRIAGE 10

// ****************************************
// count thresholds and settle timing
// ****************************************
`define MAX_DAC_LIMIT 8'h20
`define DIFF_ONE 8'h01
`define SETTLE_NS 1000000
`define CLK_NS 10

`endif

/* verif/seek_position_control_monitor.sv */
// checker for the seek sequencing outputs
// assumes it is bound onto the seek sequencing top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module seek_position_control_monitor (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic control_select, // tag strobe
	input wire logic address_bus_bit6, // zero seek bit
	input wire logic unsafe_two, // unsafe level
	input wire logic [15:0] position_error, // error sample
	input wire logic [15:0] speed_difference, // speed sample
	input wire logic [15:0] driver_signal, // drive value
	input wire logic position_servo_mode, // positioning
	input wire logic diff_count_at_one, // counter at one
	input wire logic max_at_converter, // max at converter
	input wire logic zero_seek_command_n, // zero command, low
	input wire logic on_cylinder_out, // on cylinder
	input wire logic timing_counter_clear, // timer held
	input wire logic edge_polarity_select, // polarity
	input wire logic parked_position, // parked
	input wire logic amp_block, // amp blocked
	input wire logic master_clear, // clear
	input wire logic fault_lamp, // lamp
	input wire logic unsafe_two_out, // unsafe out
	input wire logic alert_out // attention out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************
	// sequences
	// ****************
	sequence s_zero_req;
		control_select && address_bus_bit6;
	endsequence
	sequence s_unsafe_rise;
		$rose(unsafe_two);
	endsequence
	a_zero_cmd_low: assert property (s_zero_req |=> !zero_seek_command_n)
		else $error("zero seek command not issued");
	a_max_near_one: assert property (diff_count_at_one |-> max_at_converter)
		else $error("max at converter low at count one");
	a_drive_route_sel: assert property ($past(presetn) && !$past(parked_position) |->
		driver_signal == ($past(position_servo_mode) ? ($past(edge_polarity_select) ?
		$past(position_error) : -$past(position_error)) : $past(speed_difference)))
		else $error("drive source wrong");
	a_fault_clear_lamp: assert property (s_unsafe_rise |-> master_clear ##1 fault_lamp)
		else $error("unsafe did not clear or lamp");
	a_unsafe_alert_pair: assert property (unsafe_two_out == alert_out)
		else $error("unsafe and attention differ");
	a_park_forces_mode: assert property (parked_position |-> position_servo_mode && amp_block)
		else $error("parked without position mode or block");
	a_clear_polarity_high: assert property (master_clear |-> ##[0:2] edge_polarity_select)
		else $error("polarity not high after clear");
	a_on_cyl_timer: assert property (on_cylinder_out |-> !timing_counter_clear)
		else $error("timer held while on cylinder");
endmodule // seek_position_control_monitor

bind seek_position_control seek_position_control_monitor u_seek_position_control_monitor (
	.pclk, .presetn, .control_select, .address_bus_bit6, .unsafe_two, .position_error,
	.speed_difference, .driver_signal, .position_servo_mode, .diff_count_at_one,
	.max_at_converter, .zero_seek_command_n, .on_cylinder_out, .timing_counter_clear,
	.edge_polarity_select, .parked_position, .amp_block, .master_clear, .fault_lamp,
	.unsafe_two_out, .alert_out);
`default_nettype wire

/* verif/dcu_model.sv */
// model of the disk control unit issuing control-select tags
// assumes the bench calls issue_tag from its main sequence
`timescale 1ns/1ps
`default_nettype none
module dcu_model (
	input wire logic pclk, // clock
	output logic control_select, // tag strobe
	output logic address_bus_bit0, // address bit 0
	output logic address_bus_bit6 // address bit 6
);
	initial begin
		control_select = 1'b0;
		address_bus_bit0 = 1'b0;
		address_bus_bit6 = 1'b0;
	end
	// control-select tag carrying address bits 6 and 0
	// lag delays the tag by lag+1 cycles; the tag is one cycle
	task automatic issue_tag(input logic b6, input logic b0, input int lag);
		repeat (lag + 1) @(posedge pclk);
		control_select <= 1'b1;
		address_bus_bit6 <= b6;
		address_bus_bit0 <= b0;
		@(posedge pclk);
		control_select <= 1'b0;
		// bit 6 is released after the tag: show the inverse, never a stale copy
		address_bus_bit6 <= ~b6;
	endtask
endmodule // dcu_model
`default_nettype wire

/* verif/seek_position_control_bench.sv */
// self-checking bench for the seek sequencing block
// assumes the control unit model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "seek_position_control_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module seek_position_control_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rd_err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] position_error = 16'h1234, speed_difference = 16'h8765, driver_signal;
	logic track_crossing_pulse = 0, speed_in_window = 0, mech_on_cylinder_window = 0;
	logic optical_zero = 0, even_track_zone = 0, park_switch_active = 0, unsafe_two = 0;
	logic start_clear = 0, pready, pslverr, control_select, address_bus_bit0, address_bus_bit6;
	logic position_servo_mode, slow, max_at_converter, diff_count_at_one, zero_seek_command_n;
	logic zero_seek_active, forward_direction, track_zero, on_cylinder_prep, on_cylinder_out;
	logic timing_counter_clear, edge_polarity_select, odd_track_select, parked_position;
	logic amp_block, fault_lamp, master_clear, unsafe_two_out, alert_out;
	int n_errors = 0, cmp_count = 0, n;
	// diff, pulses, remaining, max at converter
	logic [31:0] rows [4] = '{32'h05020301, 32'h40013f00, 32'h21012000, 32'h21021f01};
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		position_error <= position_error + 16'h0101;
		speed_difference <= speed_difference - 16'h0011;
	end
	seek_position_control #(.SETTLE_CYCLES(5)) u_seek_position_control (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.control_select, .address_bus_bit0, .address_bus_bit6, .track_crossing_pulse,
		.speed_in_window, .mech_on_cylinder_window, .optical_zero, .even_track_zone,
		.park_switch_active, .unsafe_two, .start_clear, .position_error, .speed_difference,
		.driver_signal, .position_servo_mode, .slow, .max_at_converter, .diff_count_at_one,
		.zero_seek_command_n, .zero_seek_active, .forward_direction, .track_zero,
		.on_cylinder_prep, .on_cylinder_out, .timing_counter_clear, .edge_polarity_select,
		.odd_track_select, .parked_position, .amp_block, .fault_lamp, .master_clear,
		.unsafe_two_out, .alert_out);
	dcu_model u_dcu_model (.pclk, .control_select, .address_bus_bit0, .address_bus_bit6);
	// request stands until pready is seen high at a rising edge; data taken there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 20) n_errors++;
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			@(posedge pclk);
			track_crossing_pulse <= 1'b1;
			@(posedge pclk);
			track_crossing_pulse <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		`CHK({timing_counter_clear, edge_polarity_select, max_at_converter}, 3'b111)
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[`ST_SLOW_MOT], 1'b1)
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			apb(1, `ADDR_CTRL, {8'h03, 8'h00, rows[i][31:24], 8'h03});
			pulses(rows[i][23:16]);
			apb(0, `ADDR_DIFF, 0);
			`CHK(rd[7:0], rows[i][15:8])
			`CHK(max_at_converter, rows[i][0])
			`CHK(diff_count_at_one, 1'b0)
			apb(0, `ADDR_STATUS, 0);
			`CHK(rd[`ST_COUNT_EN], 1'b1)
		end
		$display("countdown table done");
		pulses(30);
		tick(1);
		`CHK(diff_count_at_one, 1'b1)
		pulses(1);
		apb(0, `ADDR_STATUS, 0);
		`CHK({rd[`ST_END_POS], rd[`ST_COUNT_EN]}, 2'b10)
		`CHK({position_servo_mode, max_at_converter}, 2'b11)
		`CHK(edge_polarity_select, 1'b0)
		apb(0, `ADDR_CYL, 0);
		`CHK(rd, 32'h00000003)
		u_dcu_model.issue_tag(1'b0, 1'b1, 2);
		tick(2);
		`CHK(odd_track_select, 1'b1)
		$display("target test done");
		@(posedge pclk);
		mech_on_cylinder_window <= 1'b1;
		n = 0;
		while (on_cylinder_out !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		`CHK(n >= 4 && n < 50, 1'b1)
		`CHK({on_cylinder_prep, timing_counter_clear}, 2'b10)
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[`ST_SLOW_MOT], 1'b0)
		$display("settle test done");
		@(posedge pclk);
		mech_on_cylinder_window <= 1'b0;
		apb(1, `ADDR_CTRL, 32'h02001003);
		tick(2);
		`CHK(position_servo_mode, 1'b0)
		@(posedge pclk);
		speed_in_window <= 1'b1;
		tick(2);
		`CHK({slow, position_servo_mode}, 2'b11)
		@(posedge pclk);
		speed_in_window <= 1'b0;
		$display("speed window test done");
		u_dcu_model.issue_tag(1'b1, 1'b0, 0);
		tick(3);
		`CHK({zero_seek_active, forward_direction}, 2'b10)
		@(posedge pclk);
		optical_zero <= 1'b1;
		tick(2);
		@(posedge pclk);
		even_track_zone <= 1'b1;
		tick(3);
		`CHK({track_zero, forward_direction, slow}, 3'b110)
		apb(0, `ADDR_STATUS, 0);
		`CHK(rd[`ST_END_POS], 1'b0)
		$display("zero seek test done");
		@(posedge pclk);
		unsafe_two <= 1'b1;
		tick(3);
		`CHK({fault_lamp, unsafe_two_out, alert_out}, 3'b111)
		`CHK({edge_polarity_select, forward_direction}, 2'b10)
		apb(0, `ADDR_STATUS, 0);
		`CHK({rd[`ST_CARRIAGE], rd[`ST_NORM_SEEK], rd[`ST_END_POS]}, 3'b000)
		apb(0, `ADDR_CYL, 0);
		`CHK(rd, 32'h00000000)
		@(posedge pclk);
		park_switch_active <= 1'b1;
		tick(3);
		`CHK({parked_position, amp_block, position_servo_mode}, 3'b111)
		@(posedge pclk);
		start_clear <= 1'b1;
		unsafe_two <= 1'b0;
		@(posedge pclk);
		start_clear <= 1'b0;
		tick(2);
		`CHK(unsafe_two_out, 1'b0)
		$display("unsafe test done");
		apb(1, 12'h020, 32'hffffffff);
		`CHK(rd_err, 1'b1)
		apb(0, 12'h020, 0);
		`CHK({rd_err, rd}, {1'b1, 32'h00000000})
		apb(1, `ADDR_SETTLE, 32'h00000007);
		apb(0, `ADDR_SETTLE, 0);
		`CHK({rd_err, rd}, {1'b0, 32'h00000007})
		$display("bus test done");
		complete_run();
	end
endmodule // seek_position_control_bench
`default_nettype wire
